// *** crst_rx_status.v ***
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
`include "crst_defs.vh"
// Operation
// - Report first collision bit position in 7-bit field, reset zero.
// - Add nonzero receive alignment offset into collision position.
// - Memory write error sets flag and aborts reception.
// - Memory latency error sets flag and aborts reception.
// - Set overflow flag when byte count exceeds receive buffer.
// - Combined fault is OR of integrity, protocol, collision flags.
// - In multi-frame mode, length byte above 28 sets length flag.
// - Collision sets flag and records first collision position.
// - Stop bit, SOF/EOF or byte count errors set protocol flag.
// - Protocol error stops current reception immediately.
// - Protocol and integrity flags clear at next reception start.
// - Bad parity or bad CRC sets integrity flag.
// - Integrity error does not abort the frame.
// - Parity as stop criterion suppresses integrity flag for parity.
// - Report valid bits of last byte, zero meaning whole byte.
// - Report frames received, 0 to 8, updated at receive interrupt.
// - Byte count up to 1FFh, valid from interrupt to re-enable.
// - Stop setting 10b ends reception on incorrect parity.
module crst_rx_status #(
  parameter BUF_BYTES = `CRST_BUF_BYTES
) (
  // Clock, reset, enable
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // Classic Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output wire err_o,
  // Receiver events and settings
  input wire rx_start_i,
  input wire rx_end_i,
  input wire byte_rcvd_i,
  input wire [2:0] last_bits_i,
  input wire frame_done_i,
  input wire [2:0] rx_align_i,
  input wire multi_frame_enable_i,
  input wire [1:0] stop_condition_i,
  input wire len_byte_valid_i,
  input wire [7:0] len_byte_i,
  input wire collision_i,
  input wire [6:0] collision_bit_pos_i,
  input wire stop_bit_err_i,
  input wire sof_eof_err_i,
  input wire byte_count_err_i,
  input wire parity_err_i,
  input wire crc_err_i,
  input wire dma_write_err_i,
  input wire dma_latency_err_i,
  // Status outputs to the receiver
  output wire rx_abort_o,
  output reg rx_active_o,
  output wire receive_done_interrupt_o
);

  // ****************************************
  // Status state
  // ****************************************
  reg [6:0] coll_pos_q;
  wire wr_err_q;
  wire lat_err_q;
  wire ovfl_q;
  wire len_err_q;
  wire coll_q;
  wire proto_err_q;
  wire integ_err_q;
  reg [2:0] last_bits_q;
  reg [3:0] frames_q;
  reg [3:0] frame_cnt_q;
  reg [8:0] bytes_q;
  reg [8:0] byte_cnt_q;
  reg irq_q;
  wire parity_stop;
  wire integ_hit;
  wire proto_hit;
  wire [8:0] byte_cnt_inc;
  wire [31:0] status_word;
  wire hit;
  wire wr_set;
  wire lat_set;
  wire ovfl_set;
  wire len_set;
  wire coll_set;
  wire proto_set;
  wire integ_set;

  assign parity_stop = (stop_condition_i == `CRST_STOP_ON_PARITY);
  assign integ_hit = crc_err_i | (parity_err_i & ~parity_stop);
  assign proto_hit = stop_bit_err_i | sof_eof_err_i | byte_count_err_i;
  // Saturate so a runaway frame never wraps the count
  assign byte_cnt_inc = (byte_cnt_q == 9'h1FF) ? byte_cnt_q :
                        byte_cnt_q + 9'h001;

  assign rx_abort_o = rx_active_o & (dma_write_err_i | dma_latency_err_i |
                      proto_hit | (parity_stop & parity_err_i));
  assign receive_done_interrupt_o = irq_q;

  // ****************************************
  // Flag set conditions
  // ****************************************
  // Events count only inside a reception; a start in that cycle wins
  // write error flag
  assign wr_set = rx_active_o & dma_write_err_i;
  assign lat_set = rx_active_o & dma_latency_err_i;
  // buffer overflow
  // A byte that lands on a full buffer is the first one lost
  assign ovfl_set = rx_active_o & byte_rcvd_i &
                    (byte_cnt_q >= BUF_BYTES[8:0]);
  assign len_set = rx_active_o & multi_frame_enable_i & len_byte_valid_i &
                   (len_byte_i > `CRST_MAX_LEN_BYTE);
  assign coll_set = rx_active_o & collision_i;
  assign proto_set = rx_active_o & proto_hit;
  assign integ_set = rx_active_o & integ_hit;

  // ****************************************
  // Sticky error flags
  // ****************************************
  // clear at start
  // held until start
  // One cell per flag keeps clear and set priority the same everywhere
  // Memory write error
  crst_sticky_flag i_wr_err_flag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(rx_start_i),
    .set_i(wr_set),
    .flag_o(wr_err_q)
  );
  // Memory latency error
  crst_sticky_flag i_lat_err_flag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(rx_start_i),
    .set_i(lat_set),
    .flag_o(lat_err_q)
  );
  // Receive buffer overflow
  crst_sticky_flag i_ovfl_flag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(rx_start_i),
    .set_i(ovfl_set),
    .flag_o(ovfl_q)
  );
  // Announced frame length too long
  crst_sticky_flag i_len_err_flag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(rx_start_i),
    .set_i(len_set),
    .flag_o(len_err_q)
  );
  // Collision seen
  crst_sticky_flag i_coll_flag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(rx_start_i),
    .set_i(coll_set),
    .flag_o(coll_q)
  );
  // Protocol error
  crst_sticky_flag i_proto_err_flag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(rx_start_i),
    .set_i(proto_set),
    .flag_o(proto_err_q)
  );
  // Data integrity error
  crst_sticky_flag i_integ_err_flag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(rx_start_i),
    .set_i(integ_set),
    .flag_o(integ_err_q)
  );

  // ****************************************
  // Reception tracking
  // ****************************************
  // A start in the same cycle as an event wins; the event is dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_active_o <= 1'b0;
      coll_pos_q <= 7'h00;
      last_bits_q <= 3'h0;
      frames_q <= 4'h0;
      frame_cnt_q <= 4'h0;
      bytes_q <= 9'h000;
      byte_cnt_q <= 9'h000;
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= 1'b0;
      // Counts restart with each reception; flags live in their own cells
      if (rx_start_i) begin
        rx_active_o <= 1'b1;
        coll_pos_q <= 7'h00;
        frame_cnt_q <= 4'h0;
        byte_cnt_q <= 9'h000;
      end else if (rx_active_o) begin
        if (coll_set && !coll_q) begin
          coll_pos_q <= collision_bit_pos_i + {4'h0, rx_align_i};
        end
        if (byte_rcvd_i) begin
          byte_cnt_q <= byte_cnt_inc;
        end
        if (frame_done_i && frame_cnt_q != `CRST_MAX_FRAMES) begin
          frame_cnt_q <= frame_cnt_q + 4'h1;
        end
        // Reception ends normally or by abort; results latch here
        if (rx_end_i || rx_abort_o) begin
          rx_active_o <= 1'b0;
          irq_q <= 1'b1;
          last_bits_q <= last_bits_i;
          frames_q <= (frame_done_i && frame_cnt_q != `CRST_MAX_FRAMES) ?
                      frame_cnt_q + 4'h1 : frame_cnt_q;
          bytes_q <= byte_rcvd_i ? byte_cnt_inc : byte_cnt_q;
        end
      end
    end
  end

  // ****************************************
  // Register view
  // ****************************************
  // combined fault
  assign status_word = {1'b0, coll_pos_q, wr_err_q, lat_err_q, ovfl_q,
                        integ_err_q | proto_err_q | coll_q, len_err_q,
                        coll_q, proto_err_q, integ_err_q, last_bits_q,
                        frames_q, bytes_q};
  assign hit = (adr_i == `CRST_RECEIVE_STATUS_ADDR);
  assign err_o = 1'b0;

  // Single-wait slave; other addresses read zero; writes are dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= `CRST_STATUS_RESET;
    end else if (ce_i) begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      if (cyc_i && stb_i && !ack_o && !we_i) begin
        dat_o <= hit ? status_word : 32'h00000000;
      end
    end
  end

endmodule

// ****************************************
// Sticky flag cell
// ****************************************
// Set by a hardware event, cleared only by reset or a new reception.
// The clear wins a tie so a new frame never inherits an old error.
module crst_sticky_flag #(
  parameter RESET_VALUE = 1'b0
) (
  // Clock, reset, enable
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // Flag control
  input wire clr_i,
  input wire set_i,
  // Flag state
  output reg flag_o
);

  // Frozen while the enable is low
  always @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= RESET_VALUE;
    end else if (ce_i) begin
      if (clr_i) begin
        flag_o <= 1'b0;
      end else if (set_i) begin
        flag_o <= 1'b1;
      end
    end
  end

endmodule

// *** crst_defs.vh ***
`ifndef CRST_DEFS_VH
`define CRST_DEFS_VH
// Register byte address of the receive status word
`define CRST_RECEIVE_STATUS_ADDR 8'h60
// Field positions inside receive_status
`define CRST_COLL_POS_MSB 30
`define CRST_COLL_POS_LSB 24
`define CRST_WRITE_ERR_BIT 23
`define CRST_LATENCY_ERR_BIT 22
`define CRST_OVFL_BIT 21
`define CRST_CL_ERR_BIT 20
`define CRST_LEN_ERR_BIT 19
`define CRST_COLL_DET_BIT 18
`define CRST_PROTO_ERR_BIT 17
`define CRST_INTEG_ERR_BIT 16
`define CRST_LAST_BITS_MSB 15
`define CRST_LAST_BITS_LSB 13
`define CRST_FRAMES_MSB 12
`define CRST_FRAMES_LSB 9
`define CRST_BYTES_MSB 8
`define CRST_BYTES_LSB 0
// Limits
`define CRST_MAX_FRAMES 4'h8
`define CRST_MAX_LEN_BYTE 8'h1C
`define CRST_BUF_BYTES 9'h104
// Stop-condition code that stops on a bad parity bit
`define CRST_STOP_ON_PARITY 2'h2
// Reset value of the status word
`define CRST_STATUS_RESET 32'h00000000
`endif

// *** crst_rx_status_assertions.sv ***
`timescale 1ns/10ps
// ****************
// Receive status checks
// ****************
module crst_rx_status_chk (
  input wire clk_i, input wire rst_i, input wire ce_i,
  input wire ack_o, input wire err_o, input wire [31:0] dat_o,
  input wire rx_end_i, input wire parity_err_i,
  input wire [1:0] stop_condition_i,
  input wire stop_bit_err_i, input wire sof_eof_err_i,
  input wire byte_count_err_i, input wire dma_write_err_i,
  input wire dma_latency_err_i, input wire rx_active_o,
  input wire rx_abort_o, input wire receive_done_interrupt_o
);
  // A low enable freezes the block, so the checks pause with it
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  // Causes that must stop the frame
  wire pro = stop_bit_err_i | sof_eof_err_i | byte_count_err_i;
  wire par = parity_err_i && stop_condition_i == 2'h2;
  wire why = dma_write_err_i | dma_latency_err_i | pro | par;
  sequence s_end; rx_active_o && (rx_end_i || rx_abort_o); endsequence
  sequence s_irq; receive_done_interrupt_o ##1 !receive_done_interrupt_o;
  endsequence
  property p_wr; rx_active_o && dma_write_err_i |-> rx_abort_o; endproperty
  a_wr: assert property (p_wr) else $error("no write abort");
  property p_lat; rx_active_o && dma_latency_err_i |-> rx_abort_o;
  endproperty
  a_lat: assert property (p_lat) else $error("no latency abort");
  property p_pro; rx_active_o && pro |-> rx_abort_o; endproperty
  a_pro: assert property (p_pro) else $error("no protocol abort");
  property p_par; rx_active_o && par |-> rx_abort_o; endproperty
  a_par: assert property (p_par) else $error("no parity stop");
  property p_why; rx_abort_o |-> rx_active_o && why; endproperty
  a_why: assert property (p_why) else $error("abort no cause");
  property p_cl; ack_o |-> dat_o[20] == |dat_o[18:16]; endproperty
  a_cl: assert property (p_cl) else $error("combined flag");
  property p_top; ack_o |-> !dat_o[31]; endproperty
  a_top: assert property (p_top) else $error("top bit set");
  property p_err; ack_o |-> !err_o; endproperty
  a_err: assert property (p_err) else $error("error reply");
  property p_irq; s_end |=> s_irq and !rx_active_o; endproperty
  a_irq: assert property (p_irq) else $error("done pulse");
endmodule
bind crst_rx_status crst_rx_status_chk i_chk (.*);

// *** crst_card_model.sv ***
`timescale 1ns/10ps
// ****************
// Card on the field
// ****************
module crst_card_model (
  input wire clk_i,
  output reg byte_o = 1'b0, output reg frame_o = 1'b0,
  output reg coll_o = 1'b0, output reg [6:0] pos_o = 7'h00
);
  integer sd = 75;
  // Random stalls between bytes cover slow cards as well as quick ones
  task send(input [8:0] n, input c, input [6:0] p);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      repeat ({$random(sd)} % 3) @(posedge clk_i);
      @(posedge clk_i);
      byte_o <= 1'b1;
      coll_o <= c && i < 2;
      pos_o <= p + i[6:0];
      @(posedge clk_i);
      byte_o <= 1'b0;
      coll_o <= 1'b0;
      pos_o <= ~pos_o;
    end
    @(posedge clk_i) frame_o <= 1'b1;
    @(posedge clk_i) frame_o <= 1'b0;
  endtask
endmodule

// *** crst_rx_status_tb.sv ***
`timescale 1ns/10ps
`include "crst_defs.vh"
`define CHK(n, e, s) begin compares = compares + 1; if ((s) !== (e)) begin \
  error_cnt = error_cnt + 1; $display("MISMATCH %s %h %h", n, e, s); end end
// ****************
// Receive status bench
// ****************
module crst_rx_status_tb;
  localparam [8:0] BUF = 9'h010;
  reg clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  reg mf = 1'b0, ce_i = 1'b1;
  reg [7:0] adr_i = 8'h00, ln = 8'h00;
  reg [31:0] dat_i = 32'h0, q, exp_w;
  reg [9:0] ev = 10'h000;
  reg [2:0] lb = 3'h0, al = 3'h0;
  reg [1:0] sc = 2'h0;
  reg [6:0] p;
  wire [31:0] dat_o;
  wire ack_o, bt, fd, co;
  wire [6:0] cp;
  integer seed = 75, error_cnt = 0, compares = 0, i, nf, nb, c;
  crst_rx_status #(.BUF_BYTES(BUF)) i_crst_rx_status (.clk_i, .rst_i,
    .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i,
    .dat_o, .ack_o, .err_o(), .rx_start_i(ev[0]), .rx_end_i(ev[1]),
    .byte_rcvd_i(bt), .last_bits_i(lb), .frame_done_i(fd),
    .rx_align_i(al), .multi_frame_enable_i(mf), .stop_condition_i(sc),
    .len_byte_valid_i(ev[9]), .len_byte_i(ln), .collision_i(co),
    .collision_bit_pos_i(cp), .stop_bit_err_i(ev[2]),
    .sof_eof_err_i(ev[3]), .byte_count_err_i(ev[4]),
    .parity_err_i(ev[5]), .crc_err_i(ev[6]), .dma_write_err_i(ev[7]),
    .dma_latency_err_i(ev[8]), .rx_abort_o(), .rx_active_o(),
    .receive_done_interrupt_o());
  crst_card_model i_crst_card_model (.clk_i, .byte_o(bt), .frame_o(fd),
    .coll_o(co), .pos_o(cp));
  // Flags in f: write, latency, overflow, length, collision, protocol, data
  function [31:0] ex(input [6:0] p, input [6:0] f, input [2:0] l,
    input [3:0] fr, input [8:0] n);
    ex = {1'b0, p, f[6:4], |f[2:0], f[3:0], l, fr, n};
  endfunction
  task wb(input [7:0] a, input w);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i} <= {2'h3, w, a};
    dat_i <= $random(seed);
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    {cyc_i, stb_i} <= 2'h0;
  endtask
  task pl(input integer k);
    @(posedge clk_i) ev <= 10'h001 << k;
    @(posedge clk_i) ev <= 10'h000;
  endtask
  // Each run starts afresh, so stale flags would show up here
  task er(input integer k, input [6:0] f);
    pl(0); pl(k); pl(1); wb(8'h60, 1'b0);
    `CHK("err", ex(7'h00, f, 3'h0, 4'h0, 9'h000), q)
  endtask
  task final_report;
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever #50 clk_i = ~clk_i;
  initial begin
    #3000000;
    error_cnt = error_cnt + 1;
    final_report;
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(8'h60, 1'b0); `CHK("rst", 32'h0, q)
    wb(8'h60, 1'b1); wb(8'h60, 1'b0); `CHK("ro", 32'h0, q)
    wb(8'h64, 1'b0); `CHK("hole", 32'h0, q)
    // A frozen block must not take an abort cause
    pl(0); ce_i <= 1'b0; pl(8); ce_i <= 1'b1; pl(1); wb(8'h60, 1'b0);
    `CHK("ce", 32'h0, q)
    // Random frames; an early data error must not stop the bytes
    for (i = 0; i < 8; i = i + 1) begin
      nf = (i == 0) ? 9 : 1 + {$random(seed)} % 9;
      nb = 1 + {$random(seed)} % (16 / nf);
      c = $random(seed);
      p = {$random(seed)} % 64;
      lb <= $random(seed); al <= $random(seed); mf <= 1'b1;
      pl(0);
      if (c[1]) pl(6);
      repeat (nf) i_crst_card_model.send(nb[8:0], c[0], p);
      pl(1); wb(8'h60, 1'b0);
      exp_w = ex(c[0] ? p + {4'h0, al} : 7'h0, {4'h0, c[0], 1'b0, c[1]},
        lb, nf > 8 ? 4'h8 : nf[3:0], 9'(nf * nb));
      `CHK("rx", exp_w, q)
    end
    lb <= 3'h0; ln <= 8'h1D;
    er(7, 7'h40);
    er(8, 7'h20);
    for (i = 2; i < 5; i = i + 1) er(i, 7'h02);
    er(5, 7'h01);
    er(9, 7'h08);
    ln <= 8'h1C; er(9, 7'h00);
    ln <= 8'h1D; mf <= 1'b0; er(9, 7'h00);
    sc <= 2'h2; er(5, 7'h00);
    mf <= 1'b1; pl(0); i_crst_card_model.send(BUF + 9'h1, 1'b0, 7'h0); pl(1);
    wb(8'h60, 1'b0);
    `CHK("ovf", ex(7'h0, 7'h10, 3'h0, 4'h1, BUF + 9'h1), q)
    final_report;
  end
endmodule
